// [bench/pmcc_ctrl_model.sv]
module pmcc_ctrl_model (
   // clock
   input  wire logic clk,
   // pulse pins
   output logic      step_pin,
   output logic      dir_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      step_pin = 1'b0;
      dir_pin  = 1'b1;
   end

   // ------------------------------
   // pulse train
   // ------------------------------
   // direction settles before the first edge, pin left low after
   task automatic pulses(input int n, input logic up);
      @(posedge clk);
      dir_pin <= up;
      repeat (n)
      begin
         repeat (5) @(posedge clk);
         step_pin <= 1'b1;
         repeat (5) @(posedge clk);
         step_pin <= 1'b0;
      end
   endtask
endmodule

// [bench/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------
   // signals
   // ------------------------------
   typedef struct {
      logic [11:0] a;
      logic [31:0] v;
   } pmcc_row_t;

   logic        clk;
   logic        nrst;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        step_pin;
   logic        dir_pin;
   logic        push_mode;
   logic [7:0]  data_select_inputs;
   logic [9:0]  torque_meas;
   logic        overload_detect;
   logic        drive_step;
   logic        drive_dir;
   logic [9:0]  current_cmd;
   logic [9:0]  torque_limit;
   logic        torque_limit_reached;
   logic        irq;
   int          bad_count;
   int          compares;
   int          steps;
   int          cyc;
   pmcc_row_t   rows[9];

   pmcc_top #(
      .CYC_PER_MS (10)
   ) i_dut (
      .clk                  (clk),
      .nrst                 (nrst),
      .addr                 (addr),
      .wdata                (wdata),
      .wr                   (wr),
      .rd                   (rd),
      .rdata                (rdata),
      .step_pin             (step_pin),
      .dir_pin              (dir_pin),
      .push_mode            (push_mode),
      .data_select_inputs   (data_select_inputs),
      .torque_meas          (torque_meas),
      .overload_detect      (overload_detect),
      .drive_step           (drive_step),
      .drive_dir            (drive_dir),
      .current_cmd          (current_cmd),
      .torque_limit         (torque_limit),
      .torque_limit_reached (torque_limit_reached),
      .irq                  (irq)
   );

   pmcc_ctrl_model i_ctrl (
      .clk      (clk),
      .step_pin (step_pin),
      .dir_pin  (dir_pin)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // drive step count and run limit
   always @(posedge clk)
   begin
      cyc++;
      if (drive_step === 1'b1)
         steps++;
      if (cyc == 20000)
      begin
         bad_count++;
         give_verdict();
      end
   end

   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), e, rdata);
   endtask

   task automatic wait_steps(input int n);
      for (int i = 0; i < 200 && steps < n; i++)
         @(posedge clk);
   endtask

   // one pulse, returns at the drive step
   task automatic move1();
      int s;
      s = steps;
      fork
         i_ctrl.pulses(1, 1'b1);
      join_none
      wait_steps(s + 1);
      chk("move steps", s + 1, steps);
   endtask

   task automatic done(input string name);
      $display("test %s done", name);
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------
   // tests
   // ------------------------------
   initial
   begin
      int s;
      nrst               = 1'b0;
      addr               = 12'h000;
      wdata              = 32'h0;
      wr                 = 1'b0;
      rd                 = 1'b0;
      push_mode          = 1'b0;
      data_select_inputs = 8'h00;
      torque_meas        = 10'h000;
      overload_detect    = 1'b0;
      rows[0] = '{pmcc_pkg::REG_CTRL, 32'h1};
      rows[1] = '{pmcc_pkg::REG_DELAY, 32'h64};
      rows[2] = '{pmcc_pkg::REG_STOP_CUR, 32'h1f4};
      rows[3] = '{pmcc_pkg::REG_DEV_LIMIT, 32'h2710};
      rows[4] = '{pmcc_pkg::REG_MASK, 32'h0};
      rows[5] = '{pmcc_pkg::REG_STATUS, 32'h0};
      rows[6] = '{pmcc_pkg::REG_CURRENT, 32'h3e8};
      rows[7] = '{12'h41c, 32'h3e8};
      rows[8] = '{12'h100, 32'h0};
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      cyc_n(4);
      foreach (rows[i])
         rchk(rows[i].a, rows[i].v);
      chk("torque_limit", 32'h3e8, {22'h0, torque_limit});
      done("reset values");
      reg_wr(pmcc_pkg::REG_DELAY, 32'h7d0);
      rchk(pmcc_pkg::REG_DELAY, 32'h3e8);
      reg_wr(12'h404, 32'h5dc);
      rchk(12'h404, 32'h3e8);
      reg_wr(12'h400, 32'h12c);
      reg_wr(12'h404, 32'h1f4);
      reg_wr(pmcc_pkg::REG_STOP_CUR, 32'h64);
      cyc_n(1);
      data_select_inputs <= 8'h01;
      cyc_n(8);
      chk("torque_limit", 32'h1f4, {22'h0, torque_limit});
      chk("current_cmd", 32'h1f4, {22'h0, current_cmd});
      data_select_inputs <= 8'h00;
      cyc_n(8);
      chk("torque_limit", 32'h12c, {22'h0, torque_limit});
      data_select_inputs <= 8'h01;
      done("limits and select");
      reg_wr(pmcc_pkg::REG_DELAY, 32'h3);
      move1();
      cyc_n(25);
      chk("run current", 32'h1f4, {22'h0, current_cmd});
      for (int i = 0; i < 20 && current_cmd !== 10'h064; i++)
         @(posedge clk);
      chk("stop current", 32'h64, {22'h0, current_cmd});
      reg_wr(pmcc_pkg::REG_CTRL, 32'h0);
      move1();
      cyc_n(50);
      chk("no cutback", 32'h1f4, {22'h0, current_cmd});
      done("cutback");
      cyc_n(1);
      push_mode <= 1'b1;
      reg_wr(pmcc_pkg::REG_CTRL, 32'h3);
      move1();
      cyc_n(50);
      chk("push hold", 32'h1f4, {22'h0, current_cmd});
      reg_wr(pmcc_pkg::REG_CTRL, 32'h1);
      move1();
      cyc_n(50);
      chk("push cut", 32'h64, {22'h0, current_cmd});
      done("push standstill");
      reg_wr(pmcc_pkg::REG_DEV_LIMIT, 32'h2);
      reg_wr(pmcc_pkg::REG_STATUS, 32'h7);
      reg_wr(pmcc_pkg::REG_MASK, 32'h1);
      cyc_n(1);
      torque_meas <= 10'h1f3;
      cyc_n(4);
      chk("limit flag", 32'h0, {31'h0, torque_limit_reached});
      torque_meas     <= 10'h1f4;
      overload_detect <= 1'b1;
      cyc_n(4);
      chk("limit flag", 32'h1, {31'h0, torque_limit_reached});
      chk("irq", 32'h1, {31'h0, irq});
      s = steps;
      i_ctrl.pulses(3, 1'b1);
      cyc_n(10);
      chk("held steps", s, steps);
      rchk(pmcc_pkg::REG_DEVIATION, 32'h3);
      rchk(pmcc_pkg::REG_STATE, 32'h109);
      rchk(pmcc_pkg::REG_STATUS, 32'h3);
      cyc_n(1);
      torque_meas <= 10'h000;
      cyc_n(30);
      chk("drained steps", s + 3, steps);
      chk("drive dir", 32'h1, {31'h0, drive_dir});
      chk("limit flag", 32'h0, {31'h0, torque_limit_reached});
      rchk(pmcc_pkg::REG_DEVIATION, 32'h0);
      done("stall and drain");
      i_ctrl.pulses(3, 1'b0);
      cyc_n(10);
      chk("return steps", s + 6, steps);
      chk("drive dir", 32'h0, {31'h0, drive_dir});
      rchk(pmcc_pkg::REG_DEVIATION, 32'h0);
      data_select_inputs <= 8'h00;
      cyc_n(8);
      chk("torque_limit", 32'h12c, {22'h0, torque_limit});
      done("return");
      push_mode <= 1'b0;
      cyc_n(6);
      rchk(pmcc_pkg::REG_STATUS, 32'h7);
      reg_wr(pmcc_pkg::REG_MASK, 32'h0);
      cyc_n(3);
      chk("irq masked", 32'h0, {31'h0, irq});
      reg_wr(pmcc_pkg::REG_MASK, 32'h4);
      cyc_n(3);
      chk("irq overload", 32'h1, {31'h0, irq});
      overload_detect <= 1'b0;
      reg_wr(pmcc_pkg::REG_STATUS, 32'h7);
      rchk(pmcc_pkg::REG_STATUS, 32'h0);
      cyc_n(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      done("overload and irq");
      nrst <= 1'b0;
      cyc_n(3);
      nrst <= 1'b1;
      cyc_n(4);
      rchk(pmcc_pkg::REG_DELAY, 32'h64);
      rchk(pmcc_pkg::REG_CTRL, 32'h1);
      chk("torque_limit", 32'h3e8, {22'h0, torque_limit});
      done("second reset");
      give_verdict();
   end
endmodule

// [hdl/pmcc_ms_timer.sv]
module pmcc_ms_timer #(
   parameter int unsigned CYC_PER_MS = pmcc_pkg::CYC_PER_MS
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // control
   input  wire logic       run,
   input  wire logic [9:0] delay_ms,
   // result
   output logic            expired
);

   localparam int PW = $clog2(CYC_PER_MS + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

   typedef struct packed {
      logic [PW-1:0] pre;
      logic [9:0]    ms;
      logic          done;
   } pmcc_tmr_t;

   pmcc_tmr_t q;
   pmcc_tmr_t d;

   always_comb
   begin
      d = q;
      if (!run)
      begin
         d = '0;
      end
      else if (q.ms >= delay_ms)
      begin
         d.done = 1'b1;
      end
      else if (q.pre == PRE_LAST)
      begin
         d.pre = '0;
         d.ms  = q.ms + 10'h001;
      end
      else
      begin
         d.pre = q.pre + PW'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign expired = q.done;

endmodule

// [hdl/pmcc_sync.sv]
module pmcc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // pins in, filtered level out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
      logic [W-1:0] ff3;
      logic [W-1:0] lvl;
   } pmcc_sync_t;

   pmcc_sync_t q;
   pmcc_sync_t d;

   always_comb
   begin
      d     = q;
      d.ff1 = din;
      d.ff2 = q.ff1;
      d.ff3 = q.ff2;
      for (int i = 0; i < W; i++)
      begin
         if (q.ff2[i] == q.ff3[i])
         begin
            d.lvl[i] = q.ff2[i];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign dout = q.lvl;

endmodule

// [hdl/pmcc_top.sv]
// Decided for this implementation: the plain strobed port and the placing of the registers.
module pmcc_top #(
   parameter int unsigned CYC_PER_MS = pmcc_pkg::CYC_PER_MS,
   parameter int          NSEL       = 8,
   parameter logic [7:0]  HS_DIV     = 8'h04
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // register port
   input  wire logic [11:0]     addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output logic      [31:0]     rdata,
   // controller pins
   input  wire logic            step_pin,
   input  wire logic            dir_pin,
   input  wire logic            push_mode,
   input  wire logic [NSEL-1:0] data_select_inputs,
   // drive side
   input  wire logic [9:0]      torque_meas,
   input  wire logic            overload_detect,
   output logic                 drive_step,
   output logic                 drive_dir,
   output logic      [9:0]      current_cmd,
   output logic      [9:0]      torque_limit,
   // status
   output logic                 torque_limit_reached,
   output logic                 irq
);

   localparam int NENT = 2 ** NSEL;

   typedef struct packed {
      logic                       cutback_en;
      logic                       hold_op;
      logic [9:0]                 delay;
      logic [9:0]                 stop_cur;
      logic [23:0]                dev_limit;
      logic [2:0]                 status;
      logic [2:0]                 mask;
      logic [NENT-1:0][9:0]       tbl;
      logic signed [23:0]         dev;
      logic [7:0]                 hs_cnt;
      logic                       step_prev;
      logic                       cut;
      logic                       tlr;
      logic [9:0]                 tlimit;
      logic [9:0]                 cur;
      logic                       dstep;
      logic                       ddir;
      logic                       irq;
      logic [31:0]                rdata;
   } pmcc_state_t;

   pmcc_state_t q;
   pmcc_state_t d;

   logic            step_s;
   logic            dir_s;
   logic            push_s;
   logic [NSEL-1:0] sel_s;
   logic            expired;
   logic            cmd_edge;
   logic            stall;
   logic            stopped;
   logic            tbl_hit;
   logic [NSEL-1:0] tbl_idx;
   logic [2:0]      ev;
   logic [2:0]      w1c;

   function automatic logic [23:0] pmcc_abs(input logic signed [23:0] v);
      pmcc_abs = v[23] ? 24'(-v) : 24'(v);
   endfunction

   // ---------------------------------------------------------------
   // pin synchroniser and standstill timer
   // ---------------------------------------------------------------
   pmcc_sync #(
      .W    (NSEL + 3)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  ({data_select_inputs, push_mode, dir_pin, step_pin}),
      .dout ({sel_s, push_s, dir_s, step_s})
   );

   pmcc_ms_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_timer (
      .clk        (clk),
      .nrst       (nrst),
      .run        (stopped),
      .delay_ms   (q.delay),
      .expired    (expired)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d        = q;
      cmd_edge = step_s && !q.step_prev;
      stall    = push_s && (torque_meas >= q.tlimit);
      stopped  = (q.dev == 24'sh000000) && !cmd_edge;
      tbl_hit  = (addr[11:10] == pmcc_pkg::TBL_PAGE);
      tbl_idx  = addr[NSEL+1:2];
      d.step_prev = step_s;

      // pulse accumulation and fast drain
      d.dstep  = 1'b0;
      d.hs_cnt = (q.hs_cnt == 8'h00) ? HS_DIV : q.hs_cnt - 8'h01;
      if (cmd_edge)
      begin
         d.dev = dir_s ? q.dev + 24'sh000001 : q.dev - 24'sh000001;
      end
      if (q.dev != 24'sh000000 && !stall && q.hs_cnt == 8'h00)
      begin
         d.dstep = 1'b1;
         d.ddir  = !q.dev[23];
         d.dev   = (q.dev[23] ? d.dev + 24'sh000001 : d.dev - 24'sh000001);
      end

      // current selection
      d.tlimit = q.tbl[sel_s];
      d.cut    = q.cutback_en && expired && !(push_s && q.hold_op);
      d.cur    = q.cut ? q.stop_cur : q.tlimit;
      d.tlr    = stall;

      // events
      ev[pmcc_pkg::EV_TORQUE]    = stall && !q.tlr;
      ev[pmcc_pkg::EV_DEVIATION] = pmcc_abs(q.dev) > q.dev_limit;
      ev[pmcc_pkg::EV_OVERLOAD]  = overload_detect && !push_s;
      w1c = (wr && addr == pmcc_pkg::REG_STATUS) ? wdata[2:0] : 3'h0;
      d.status = (q.status & ~w1c) | ev;
      d.irq    = |(q.status & q.mask);

      // register writes
      if (wr)
      begin
         if (addr == pmcc_pkg::REG_CTRL)
         begin
            d.cutback_en = wdata[pmcc_pkg::CTRL_CUTBACK_BIT];
            d.hold_op    = wdata[pmcc_pkg::CTRL_HOLD_OP_BIT];
         end
         if (addr == pmcc_pkg::REG_DELAY)
         begin
            d.delay = pmcc_pkg::pmcc_clamp(wdata, pmcc_pkg::DELAY_MAX_MS);
         end
         if (addr == pmcc_pkg::REG_STOP_CUR)
         begin
            d.stop_cur = pmcc_pkg::pmcc_clamp(wdata, pmcc_pkg::OP_CUR_MAX);
         end
         if (addr == pmcc_pkg::REG_DEV_LIMIT)
         begin
            d.dev_limit = wdata[23:0];
         end
         if (addr == pmcc_pkg::REG_MASK)
         begin
            d.mask = wdata[2:0];
         end
         if (tbl_hit)
         begin
            d.tbl[tbl_idx] = pmcc_pkg::pmcc_clamp(wdata, pmcc_pkg::OP_CUR_MAX);
         end
      end

      // register reads, data in the next cycle only
      d.rdata = 32'h00000000;
      if (rd)
      begin
         unique case (addr)
            pmcc_pkg::REG_CTRL:      d.rdata = {30'h0, q.hold_op, q.cutback_en};
            pmcc_pkg::REG_DELAY:     d.rdata = {22'h0, q.delay};
            pmcc_pkg::REG_STOP_CUR:  d.rdata = {22'h0, q.stop_cur};
            pmcc_pkg::REG_DEV_LIMIT: d.rdata = {8'h00, q.dev_limit};
            pmcc_pkg::REG_STATUS:    d.rdata = {29'h0, q.status};
            pmcc_pkg::REG_MASK:      d.rdata = {29'h0, q.mask};
            pmcc_pkg::REG_DEVIATION: d.rdata = {{8{q.dev[23]}}, q.dev};
            pmcc_pkg::REG_CURRENT:   d.rdata = {22'h0, q.cur};
            pmcc_pkg::REG_STATE:
            begin
               d.rdata = 32'h00000000;
               d.rdata[pmcc_pkg::ST_PUSH_BIT]    = push_s;
               d.rdata[pmcc_pkg::ST_STOPPED_BIT] = stopped;
               d.rdata[pmcc_pkg::ST_CUT_BIT]     = q.cut;
               d.rdata[pmcc_pkg::ST_TLR_BIT]     = q.tlr;
               d.rdata[pmcc_pkg::ST_SEL_LSB +: NSEL] = sel_s;
            end
            default:
            begin
               d.rdata = tbl_hit ? {22'h0, q.tbl[tbl_idx]} : 32'h00000000;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         q            <= '0;
         q.cutback_en <= pmcc_pkg::CUTBACK_EN_RST;
         q.hold_op    <= pmcc_pkg::HOLD_OP_RST;
         q.delay      <= pmcc_pkg::DELAY_RST_MS;
         q.stop_cur   <= pmcc_pkg::STOP_CUR_RST;
         q.dev_limit  <= pmcc_pkg::DEV_LIMIT_RST;
         q.tlimit     <= pmcc_pkg::OP_CUR_RST;
         q.cur        <= pmcc_pkg::OP_CUR_RST;
         q.hs_cnt     <= HS_DIV;
         for (int i = 0; i < NENT; i++)
         begin
            q.tbl[i] <= pmcc_pkg::OP_CUR_RST;
         end
      end
      else
      begin
         q <= d;
      end
   end

   assign rdata                = q.rdata;
   assign drive_step           = q.dstep;
   assign drive_dir            = q.ddir;
   assign current_cmd          = q.cur;
   assign torque_limit         = q.tlimit;
   assign torque_limit_reached = q.tlr;
   assign irq                  = q.irq;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic [31:0] stop_cyc_q;

   always_ff @(posedge clk)
   begin
      if (!nrst || !stopped)
      begin
         stop_cyc_q <= 32'h00000000;
      end
      else
      begin
         stop_cyc_q <= stop_cyc_q + 32'h00000001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_cutback_off: assert property (
      !q.cutback_en |=> !q.cut) else $error("cutback active while disabled");
   a_delay_range: assert property (
      q.delay <= pmcc_pkg::DELAY_MAX_MS) else $error("cutback delay above range");
   a_cut_wait: assert property (
      $rose(q.cut) |-> stop_cyc_q >= 32'(q.delay) * CYC_PER_MS)
      else $error("stop current before delay ran out");
   a_push_hold: assert property (
      push_s && q.hold_op |=> !q.cut) else $error("cutback while holding push current");
   a_push_stopcur: assert property (
      q.cut |-> ##1 current_cmd == $past(q.stop_cur)) else $error("stop current not applied");
   a_tlr_set: assert property (
      push_s && torque_meas >= q.tlimit |=> torque_limit_reached)
      else $error("torque limit flag missed");
   a_tlr_clear: assert property (
      !push_s |=> !torque_limit_reached) else $error("torque flag outside push mode");
   a_stall_accum: assert property (
      stall && cmd_edge && dir_s |=> q.dev == $past(q.dev) + 24'sh000001)
      else $error("pulse lost while stalled");
   a_drain_step: assert property (
      drive_step |-> $past(q.dev) != 24'sh000000 && !$past(stall))
      else $error("drive step without pending pulses");
   a_dev_alarm: assert property (
      pmcc_abs(q.dev) > q.dev_limit |=> q.status[pmcc_pkg::EV_DEVIATION])
      else $error("deviation alarm missed");
   a_sel_limit: assert property (
      ##1 torque_limit == $past(q.tbl[sel_s])) else $error("limit not from selected entry");
   a_tbl_range: assert property (
      q.tbl[sel_s] <= pmcc_pkg::OP_CUR_MAX) else $error("table current above range");
   a_ovl_block: assert property (
      $rose(q.status[pmcc_pkg::EV_OVERLOAD]) |-> $past(!push_s && overload_detect))
      else $error("overload alarm raised in push mode");

   // ---------------------------------------------------------------
   // current and motion
   // ---------------------------------------------------------------
   a_run_current: assert property (
      !q.cut |=> current_cmd == $past(q.tlimit))
      else $error("operating current not applied");
   a_cut_release: assert property (
      !stopped |-> ##2 !q.cut)
      else $error("stop current kept while moving");
   a_cur_range: assert property (
      current_cmd <= pmcc_pkg::OP_CUR_MAX)
      else $error("commanded current above range");
   a_hold_steps: assert property (
      stall |=> !drive_step)
      else $error("drive step while stalled");
   a_drain_dir: assert property (
      drive_step |-> drive_dir == !$past(q.dev[23]))
      else $error("drive step in wrong direction");
   a_tlr_event: assert property (
      $rose(torque_limit_reached) |-> q.status[pmcc_pkg::EV_TORQUE])
      else $error("torque event not recorded");
   a_dev_sticky: assert property (
      q.status[pmcc_pkg::EV_DEVIATION] && !w1c[pmcc_pkg::EV_DEVIATION]
      |=> q.status[pmcc_pkg::EV_DEVIATION])
      else $error("deviation alarm lost");

   // ---------------------------------------------------------------
   // register port and interrupt
   // ---------------------------------------------------------------
   a_irq_level: assert property (
      ##1 irq == $past(|(q.status & q.mask)))
      else $error("interrupt not following status");
   a_rdata_idle: assert property (
      !$past(rd) |-> rdata == 32'h00000000)
      else $error("read data outside read slot");

   // ---------------------------------------------------------------
   // covers
   // ---------------------------------------------------------------
   c_push_reach: cover property (push_s ##[1:20] $rose(torque_limit_reached));
   c_cutback:    cover property ($rose(q.cut));
   c_drain:      cover property (stall ##1 !stall ##[1:10] drive_step);
   c_irq:        cover property ($rose(irq));
   c_push_hold:  cover property (push_s && q.hold_op && expired);

endmodule

// [inc/pmcc_pkg.sv]
package pmcc_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // limits and reset values
   // ---------------------------------------------------------------
   localparam logic [9:0]  DELAY_MAX_MS   = 10'h3e8;
   localparam logic [9:0]  DELAY_RST_MS   = 10'h064;
   localparam logic [9:0]  OP_CUR_MAX     = 10'h3e8;
   localparam logic [9:0]  OP_CUR_RST     = 10'h3e8;
   localparam logic [9:0]  STOP_CUR_RST   = 10'h1f4;
   localparam logic        CUTBACK_EN_RST = 1'b1;
   localparam logic        HOLD_OP_RST    = 1'b0;
   localparam logic [23:0] DEV_LIMIT_RST  = 24'h002710;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_DELAY     = 12'h004;
   localparam logic [11:0] REG_STOP_CUR  = 12'h008;
   localparam logic [11:0] REG_DEV_LIMIT = 12'h00c;
   localparam logic [11:0] REG_STATUS    = 12'h010;
   localparam logic [11:0] REG_MASK      = 12'h014;
   localparam logic [11:0] REG_STATE     = 12'h018;
   localparam logic [11:0] REG_DEVIATION = 12'h01c;
   localparam logic [11:0] REG_CURRENT   = 12'h020;
   localparam logic [1:0]  TBL_PAGE      = 2'h1;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_CUTBACK_BIT = 0;
   localparam int CTRL_HOLD_OP_BIT = 1;
   localparam int EV_TORQUE        = 0;
   localparam int EV_DEVIATION     = 1;
   localparam int EV_OVERLOAD      = 2;
   localparam int ST_PUSH_BIT      = 0;
   localparam int ST_STOPPED_BIT   = 1;
   localparam int ST_CUT_BIT       = 2;
   localparam int ST_TLR_BIT       = 3;
   localparam int ST_SEL_LSB       = 8;

   // clamps a written value into 0..max
   function automatic logic [9:0] pmcc_clamp(input logic [31:0] v, input logic [9:0] max);
      pmcc_clamp = (v > {22'h000000, max}) ? max : v[9:0];
   endfunction

endpackage
